// [rtl/ctt_pkg.sv]
package ctt_pkg;
  localparam logic [15:0] ADDR_CTRL = 16'hff78;
  localparam logic [15:0] ADDR_TICK_LO = 16'hff79;
  localparam logic [15:0] ADDR_TICK_HI = 16'hff7a;
  localparam logic [15:0] ADDR_IRQ_EN = 16'hffe6;
  localparam logic [15:0] ADDR_IRQ_PEND = 16'hfff6;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_COUNT = 8'h00;
  // Tick bit positions of the 16, 8, 2 and 1 Hz taps
  localparam int TAP_16HZ = 3;
  localparam int TAP_8HZ = 4;
  localparam int TAP_2HZ = 6;
  localparam int TAP_1HZ = 7;
  localparam longint CLK_HZ = 100000000;
  localparam longint TICK_HZ = 256;
  localparam int TICK_DIV = int'(CLK_HZ / TICK_HZ);
  // Hold window, microseconds; longest time rounds down
  localparam longint HOLD_US = 1500;
  localparam int HOLD_CYC = int'(HOLD_US * CLK_HZ / 1000000);
endpackage

// [rtl/ctt_clock_timer.sv]
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module ctt_clock_timer
  import ctt_pkg::*;
#(
  parameter int TICK_DIV_P = TICK_DIV,
  parameter int HOLD_CYC_P = HOLD_CYC
) (
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST_B,
  // Register port
  input wire logic [15:0] I_ADDR,
  input wire logic [3:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [3:0] O_RDATA,
  // Interrupt request
  output logic O_IRQ
);

  typedef struct packed {
    logic [23:0] div;
    logic [7:0] cnt;
    logic [3:0] hi_view;
    logic hold;
    logic [23:0] hold_cnt;
    logic run;
    logic [3:0] en;
    logic [3:0] pend;
    logic [3:0] rdata;
    logic irq;
  } ctt_state_t;

  ctt_state_t s_q;
  ctt_state_t s_d;

  logic tick;
  logic [7:0] cnt_nx;
  logic [3:0] fall;
  logic wr_ctrl;
  logic wr_pend;
  logic wr_en;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_ctrl = I_WR && (I_ADDR == ADDR_CTRL);
    wr_en = I_WR && (I_ADDR == ADDR_IRQ_EN);
    wr_pend = I_WR && (I_ADDR == ADDR_IRQ_PEND);
    tick = s_q.run && (s_q.div == 24'(TICK_DIV_P - 1));
    // Prescaler runs only while counting
    if (!s_q.run || tick) begin
      s_d.div = 24'h000000;
    end else begin
      s_d.div = s_q.div + 24'h000001;
    end
    cnt_nx = s_q.cnt;
    if (tick) begin
      cnt_nx = s_q.cnt + 8'h01;
    end
    if (wr_ctrl && I_WDATA[CTRL_CLR_BIT]) begin
      cnt_nx = RST_COUNT;
      s_d.div = 24'h000000;
    end
    s_d.cnt = cnt_nx;
    fall[0] = s_q.cnt[TAP_16HZ] && !cnt_nx[TAP_16HZ];
    fall[1] = s_q.cnt[TAP_8HZ] && !cnt_nx[TAP_8HZ];
    fall[2] = s_q.cnt[TAP_2HZ] && !cnt_nx[TAP_2HZ];
    fall[3] = s_q.cnt[TAP_1HZ] && !cnt_nx[TAP_1HZ];
    if (wr_ctrl) begin
      s_d.run = I_WDATA[CTRL_RUN_BIT];
    end
    if (wr_en) begin
      s_d.en = I_WDATA;
    end
    // Set wins over a same-cycle clear
    s_d.pend = (wr_pend ? (s_q.pend & ~I_WDATA) : s_q.pend) | fall;
    // High view: held after a low read, count keeps running underneath
    if (I_RD && (I_ADDR == ADDR_TICK_LO)) begin
      s_d.hold = 1'b1;
      s_d.hold_cnt = 24'h000000;
    end else if (s_q.hold) begin
      if ((I_RD && (I_ADDR == ADDR_TICK_HI)) || s_q.hold_cnt == 24'(HOLD_CYC_P - 1)) begin
        s_d.hold = 1'b0;
      end
      s_d.hold_cnt = s_q.hold_cnt + 24'h000001;
    end
    if (!s_d.hold || (wr_ctrl && I_WDATA[CTRL_CLR_BIT])) begin
      s_d.hi_view = cnt_nx[7:4];
    end
    s_d.rdata = 4'h0;
    if (I_RD) begin
      case (I_ADDR)
        ADDR_CTRL: s_d.rdata = {3'b000, s_q.run};
        ADDR_TICK_LO: s_d.rdata = s_q.cnt[3:0];
        ADDR_TICK_HI: s_d.rdata = s_q.hi_view;
        ADDR_IRQ_EN: s_d.rdata = s_q.en;
        ADDR_IRQ_PEND: s_d.rdata = s_q.pend;
        default: s_d.rdata = 4'h0;
      endcase
    end
    s_d.irq = |(s_d.pend & s_d.en);
    if (!I_RST_B) begin
      s_d = '0;
      s_d.cnt = RST_COUNT;
      s_d.hi_view = RST_NIBBLE;
      s_d.en = RST_NIBBLE;
      s_d.pend = RST_NIBBLE;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    s_q <= s_d;
  end

  assign O_RDATA = s_q.rdata;
  assign O_IRQ = s_q.irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_B);

  a_irq_follows: assert property (##1 O_IRQ == |($past(s_d.pend) & $past(s_d.en)))
    else $error("irq not pending and enable");
  a_fall_sets: assert property (fall[0] |=> s_q.pend[0])
    else $error("16 Hz edge lost");
  a_w1c_clears: assert property (wr_pend && I_WDATA[1] && !fall[1] |=> !s_q.pend[1])
    else $error("pending not cleared");
  a_w0_keeps: assert property (wr_pend && !I_WDATA[2] && s_q.pend[2] |=> s_q.pend[2])
    else $error("pending lost on zero write");
  a_clear_zero: assert property (wr_ctrl && I_WDATA[1] |=> s_q.cnt == 8'h00)
    else $error("clear did not zero counter");
  a_stop_holds: assert property (!s_q.run && !wr_ctrl |=> $stable(s_q.cnt))
    else $error("stopped counter moved");
  a_ctrl_read: assert property (I_RD && I_ADDR == ADDR_CTRL |=> O_RDATA[3:1] == 3'b000)
    else $error("control upper bits nonzero");
  a_en_write: assert property (wr_en |=> s_q.en == $past(I_WDATA))
    else $error("enable write lost");
  a_hold_view: assert property (s_q.hold && !(wr_ctrl && I_WDATA[1]) && $past(I_RST_B)
    |=> $stable(s_q.hi_view) or !s_q.hold)
    else $error("high view moved during hold");

  // ---------------------------------------------------------------
  // Helper terms
  // ---------------------------------------------------------------
  logic clr_req;
  logic [3:0] cnt_lo;
  logic [3:0] cnt_hi;
  assign clr_req = wr_ctrl && I_WDATA[CTRL_CLR_BIT];
  assign cnt_lo = s_q.cnt[3:0];
  assign cnt_hi = s_q.cnt[7:4];

  // ---------------------------------------------------------------
  // Named sequences
  // ---------------------------------------------------------------
  sequence s_clr_write;
    wr_ctrl && I_WDATA[CTRL_CLR_BIT];
  endsequence
  sequence s_low_read;
    I_RD && (I_ADDR == ADDR_TICK_LO);
  endsequence
  sequence s_hi_read;
    I_RD && (I_ADDR == ADDR_TICK_HI);
  endsequence
  sequence s_stopped_zero;
    !s_q.run ##1 (s_q.cnt == RST_COUNT);
  endsequence

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  a_rst_cnt: assert property (disable iff (1'b0) !I_RST_B |=> s_q.cnt == RST_COUNT)
    else $error("counter not zero after reset");

  a_rst_div: assert property (disable iff (1'b0) !I_RST_B |=> s_q.div == 24'h000000)
    else $error("prescaler not zero after reset");

  a_rst_run: assert property (disable iff (1'b0) !I_RST_B |=> !s_q.run)
    else $error("run bit set after reset");

  a_rst_en: assert property (disable iff (1'b0) !I_RST_B |=> s_q.en == RST_NIBBLE)
    else $error("enables set after reset");

  a_rst_pend: assert property (disable iff (1'b0) !I_RST_B |=> s_q.pend == RST_NIBBLE)
    else $error("flags set after reset");

  a_rst_irq: assert property (disable iff (1'b0) !I_RST_B |=> !O_IRQ)
    else $error("request high after reset");

  a_rst_rdata: assert property (disable iff (1'b0) !I_RST_B |=> O_RDATA == 4'h0)
    else $error("read data nonzero after reset");

  a_rst_hold: assert property (disable iff (1'b0) !I_RST_B |=> !s_q.hold)
    else $error("hold set after reset");

  a_rst_view: assert property (disable iff (1'b0) !I_RST_B |=> s_q.hi_view == RST_NIBBLE)
    else $error("high view nonzero after reset");

  // ---------------------------------------------------------------
  // Counting, clear and run
  // ---------------------------------------------------------------
  a_div_range: assert property (s_q.div <= 24'(TICK_DIV_P - 1))
    else $error("prescaler out of range");

  a_div_idle: assert property (!s_q.run |=> s_q.div == 24'h000000)
    else $error("prescaler moved while stopped");

  a_tick_step: assert property (tick && !clr_req |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
    else $error("tick did not advance counter");

  a_no_tick_hold: assert property (!tick && !clr_req |=> $stable(s_q.cnt))
    else $error("counter moved without tick");

  a_tick_period: assert property (tick |=> !tick)
    else $error("ticks back to back");

  a_carry_wrap: assert property (tick && !clr_req && cnt_lo == 4'hf |=> cnt_lo == 4'h0)
    else $error("low half did not wrap");

  a_hi_no_carry: assert property (tick && !clr_req && cnt_lo != 4'hf |=> $stable(cnt_hi))
    else $error("upper half moved without carry");

  a_hi_carry: assert property (tick && !clr_req && cnt_lo == 4'hf |=> $changed(cnt_hi))
    else $error("carry lost");

  a_clr_div: assert property (s_clr_write |=> s_q.div == 24'h000000)
    else $error("clear left prescaler phase");

  a_clr_run_keep: assert property (clr_req && I_WDATA[CTRL_RUN_BIT] |=> s_q.run)
    else $error("clear while running stopped");

  a_clr_stop_keep: assert property (clr_req && !I_WDATA[CTRL_RUN_BIT] |=> s_stopped_zero)
    else $error("stopped clear did not hold zero");

  a_clr_view: assert property (s_clr_write |=> s_q.hi_view == RST_NIBBLE)
    else $error("clear left high view");

  a_run_set: assert property (wr_ctrl && I_WDATA[CTRL_RUN_BIT] |=> s_q.run)
    else $error("run not set");

  a_run_clr: assert property (wr_ctrl && !I_WDATA[CTRL_RUN_BIT] |=> !s_q.run)
    else $error("run not cleared");

  a_run_hold: assert property (!wr_ctrl |=> $stable(s_q.run))
    else $error("run moved without write");

  a_ctrl_read_run: assert property (I_RD && I_ADDR == ADDR_CTRL |=> O_RDATA[0] == $past(s_q.run))
    else $error("run read wrong");

  a_ctrl_clr_bit: assert property (I_RD && I_ADDR == ADDR_CTRL |=> !O_RDATA[CTRL_CLR_BIT])
    else $error("clear strobe read nonzero");

  a_tick_wr_ignored: assert property (I_WR && (I_ADDR == ADDR_TICK_LO || I_ADDR == ADDR_TICK_HI)
    && !tick |=> $stable(s_q.cnt))
    else $error("tick word write moved counter");

  // ---------------------------------------------------------------
  // Edges and pending flags
  // ---------------------------------------------------------------
  a_fall8_sets: assert property (fall[1] |=> s_q.pend[1])
    else $error("8 Hz edge lost");

  a_fall2_sets: assert property (fall[2] |=> s_q.pend[2])
    else $error("2 Hz edge lost");

  a_fall1_sets: assert property (fall[3] |=> s_q.pend[3])
    else $error("1 Hz edge lost");

  a_fell_16hz: assert property ($fell(s_q.cnt[TAP_16HZ]) && $past(I_RST_B) |-> s_q.pend[0])
    else $error("16 Hz fall without flag");

  a_fell_8hz: assert property ($fell(s_q.cnt[TAP_8HZ]) && $past(I_RST_B) |-> s_q.pend[1])
    else $error("8 Hz fall without flag");

  a_fell_2hz: assert property ($fell(s_q.cnt[TAP_2HZ]) && $past(I_RST_B) |-> s_q.pend[2])
    else $error("2 Hz fall without flag");

  a_fell_1hz: assert property ($fell(s_q.cnt[TAP_1HZ]) && $past(I_RST_B) |-> s_q.pend[3])
    else $error("1 Hz fall without flag");

  a_fall16_next: assert property (fall[0] |=> !s_q.cnt[TAP_16HZ])
    else $error("16 Hz event without fall");

  a_fall1_next: assert property (fall[3] |=> !s_q.cnt[TAP_1HZ])
    else $error("1 Hz event without fall");

  a_w1c_16: assert property (wr_pend && I_WDATA[0] && !fall[0] |=> !s_q.pend[0])
    else $error("16 Hz flag not cleared");

  a_w1c_2: assert property (wr_pend && I_WDATA[2] && !fall[2] |=> !s_q.pend[2])
    else $error("2 Hz flag not cleared");

  a_w1c_1: assert property (wr_pend && I_WDATA[3] && !fall[3] |=> !s_q.pend[3])
    else $error("1 Hz flag not cleared");

  a_w0_16: assert property (wr_pend && !I_WDATA[0] && s_q.pend[0] |=> s_q.pend[0])
    else $error("16 Hz flag lost on zero write");

  a_w0_8: assert property (wr_pend && !I_WDATA[1] && s_q.pend[1] |=> s_q.pend[1])
    else $error("8 Hz flag lost on zero write");

  a_w0_1: assert property (wr_pend && !I_WDATA[3] && s_q.pend[3] |=> s_q.pend[3])
    else $error("1 Hz flag lost on zero write");

  a_set_wins: assert property (wr_pend && I_WDATA[0] && fall[0] |=> s_q.pend[0])
    else $error("edge lost to clear");

  a_pend_quiet: assert property (!(|fall) && !wr_pend |=> $stable(s_q.pend))
    else $error("flags moved without cause");

  // ---------------------------------------------------------------
  // Reads and request
  // ---------------------------------------------------------------
  a_pend_read: assert property (I_RD && I_ADDR == ADDR_IRQ_PEND |=> O_RDATA == $past(s_q.pend))
    else $error("pending read wrong");

  a_en_read: assert property (I_RD && I_ADDR == ADDR_IRQ_EN |=> O_RDATA == $past(s_q.en))
    else $error("enable read wrong");

  a_lo_read: assert property (s_low_read |=> O_RDATA == $past(cnt_lo))
    else $error("low word read wrong");

  a_hi_read: assert property (s_hi_read |=> O_RDATA == $past(s_q.hi_view))
    else $error("high word read wrong");

  a_idle_rdata: assert property (!I_RD |=> O_RDATA == 4'h0)
    else $error("read data without read");

  a_en_hold: assert property (!wr_en |=> $stable(s_q.en))
    else $error("enables moved without write");

  a_irq_mask: assert property (s_q.en == 4'h0 && !wr_en |=> !O_IRQ)
    else $error("request while all masked");

  a_irq_hold: assert property (O_IRQ && !wr_pend && !wr_en |=> O_IRQ)
    else $error("request dropped while pending");

  a_irq_now: assert property (O_IRQ == |(s_q.pend & s_q.en))
    else $error("request differs from flags");

  a_irq_rise: assert property (fall[0] && s_q.en[0] && !wr_en |=> O_IRQ)
    else $error("enabled edge gave no request");

  // ---------------------------------------------------------------
  // High word hold
  // ---------------------------------------------------------------
  a_low_read_holds: assert property (s_low_read |=> s_q.hold)
    else $error("low read did not hold");

  a_hi_read_frees: assert property (s_hi_read |=> !s_q.hold)
    else $error("high read did not release");

  a_hold_limit: assert property (s_q.hold |-> s_q.hold_cnt < 24'(HOLD_CYC_P))
    else $error("hold window overrun");

  a_hold_expire: assert property (s_q.hold && s_q.hold_cnt == 24'(HOLD_CYC_P - 1) && !I_RD
    |=> !s_q.hold)
    else $error("hold did not expire");

  a_hold_step: assert property (s_q.hold && !(I_RD && I_ADDR == ADDR_TICK_LO)
    |=> s_q.hold_cnt == $past(s_q.hold_cnt) + 24'h000001)
    else $error("hold timer stalled");

  a_free_track: assert property (!s_q.hold |-> s_q.hi_view == cnt_hi)
    else $error("high view stale when free");

endmodule

// [sim/ctt_clock_timer_test.sv]
`timescale 1ns/10ps
module ctt_clock_timer_test
  import ctt_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq;
  logic [15:0] addr = 16'h0000;
  logic [3:0] wd = 4'h0;
  logic [3:0] rdat;
  logic [3:0] v;
  logic [3:0] lo;
  logic [3:0] hi;
  logic [7:0] c1;
  int n_errors = 0;
  int checked = 0;
  localparam logic [15:0] ADRS [6] = '{ADDR_CTRL, ADDR_TICK_LO, ADDR_TICK_HI, ADDR_IRQ_EN,
    ADDR_IRQ_PEND, 16'hff7b};

  localparam int SIM_DIV = 4;
  localparam int SIM_HOLD = 20;

  function automatic logic [7:0] exp_cnt(input int n);
    return 8'(n / SIM_DIV);
  endfunction

  ctt_clock_timer #(.TICK_DIV_P(SIM_DIV), .HOLD_CYC_P(SIM_HOLD)) ctt_clock_timer_i (.I_REF_CLK(clk),
    .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat),
    .O_IRQ(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the read strobe
  task automatic rd_reg(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    void'($urandom(32'hb8a2));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    foreach (ADRS[i]) begin
      rd_reg(ADRS[i], v);
      chk(v, 0);
    end
    repeat (4) begin
      v = 4'($urandom());
      wr_reg(ADDR_CTRL, v);
      rd_reg(ADDR_CTRL, lo);
      chk(lo, {3'b000, v[0]});
      wr_reg(ADDR_IRQ_EN, v);
      rd_reg(ADDR_IRQ_EN, lo);
      chk(lo, v);
    end
    wr_reg(ADDR_CTRL, 4'h2);
    wr_reg(ADDR_TICK_LO, 4'($urandom()));
    wr_reg(ADDR_TICK_HI, 4'($urandom()));
    rd_reg(ADDR_TICK_LO, lo);
    rd_reg(ADDR_TICK_HI, hi);
    chk({hi, lo}, 0);
    wr_reg(ADDR_IRQ_EN, 4'h0);
    wr_reg(ADDR_IRQ_PEND, 4'hf);
    wr_reg(ADDR_CTRL, 4'h3);
    repeat (1100) begin
      @(negedge clk);
      chk(irq, 0);
    end
    wr_reg(ADDR_CTRL, 4'h0);
    rd_reg(ADDR_TICK_LO, lo);
    rd_reg(ADDR_TICK_HI, hi);
    c1 = {hi, lo};
    chk(c1 >= 17 && c1 <= 21, 1);
    repeat (100) @(posedge clk);
    rd_reg(ADDR_TICK_LO, lo);
    rd_reg(ADDR_TICK_HI, hi);
    chk({hi, lo}, c1);
    rd_reg(ADDR_IRQ_PEND, v);
    chk(v, 4'hf);
    wr_reg(ADDR_IRQ_EN, 4'h8);
    @(negedge clk);
    chk(irq, 1);
    wr_reg(ADDR_IRQ_PEND, 4'h0);
    rd_reg(ADDR_IRQ_PEND, v);
    chk(v, 4'hf);
    wr_reg(ADDR_IRQ_PEND, 4'h8);
    rd_reg(ADDR_IRQ_PEND, v);
    chk({irq, v}, 5'h07);
    wr_reg(ADDR_CTRL, 4'h3);
    repeat (20) @(posedge clk);
    wr_reg(ADDR_CTRL, 4'h0);
    rd_reg(ADDR_TICK_LO, lo);
    chk(lo >= 3 && lo <= 7, 1);
    wr_reg(ADDR_CTRL, 4'h3);
    repeat (62) @(posedge clk);
    rd_reg(ADDR_TICK_LO, lo);
    rd_reg(ADDR_TICK_HI, hi);
    chk({hi, lo}, exp_cnt(63));
    rd_reg(ADDR_TICK_LO, lo);
    repeat (25) @(posedge clk);
    rd_reg(ADDR_TICK_HI, hi);
    chk(hi, exp_cnt(94) >> 4);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(ADDR_TICK_LO, lo);
    rd_reg(ADDR_IRQ_PEND, v);
    chk({lo, v}, 0);
    rd_reg(ADDR_CTRL, v);
    chk(v, 0);
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
endmodule
